// File: verilog/bcpp_pkg.sv
`default_nettype none
package bcpp_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [31:0] TWO_DATA_ADDR = 32'hfffff008;
  localparam logic [31:0] FOUR_DATA_ADDR = 32'hfffff00c;
  localparam logic [31:0] TWO_DIR_ADDR = 32'hfffff028;
  localparam logic [31:0] FOUR_DIR_ADDR = 32'hfffff02c;
  localparam logic [31:0] TWO_FSEL_ADDR = 32'hfffff048;
  localparam logic [31:0] FOUR_FSEL_ADDR = 32'hfffff04c;
  localparam logic [31:0] TWO_PU_ADDR = 32'hfffffa48;
  localparam logic [31:0] FOUR_PU_ADDR = 32'hfffffa4c;
  localparam logic [31:0] TWO_PD_ADDR = 32'hfffffa68;
  localparam logic [31:0] FOUR_PD_ADDR = 32'hfffffa6c;
  // ---------------------------------------------------------------
  // Reset values and fixed bits
  // ---------------------------------------------------------------
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] FSEL_RESET = 8'h00;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [7:0] FOUR_DIR_FIXED_ONES = 8'hc0;
  localparam logic ALT_IN_IDLE = 1'b1;
  // ---------------------------------------------------------------
  // Alternate function pin positions of the four-pin port
  // ---------------------------------------------------------------
  localparam int HOLD_REQUEST_POS = 3;
  localparam int HOLD_GRANT_POS = 2;
  localparam int BUS_CLOCK_POS = 1;
  localparam int WAIT_POS = 0;
  // ---------------------------------------------------------------
  // Bus access encoding
  // ---------------------------------------------------------------
  localparam logic [3:0] BIT_ACCESS_STRB = 4'h2;
  localparam int BIT_INDEX_LSB = 8;
  localparam int BIT_VALUE_POS = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 25;
  localparam int BUS_CLOCK_HALF_NS = 25;
  localparam int BUS_CLOCK_HALF_CYCLES = (BUS_CLOCK_HALF_NS / MCLK_PERIOD_NS < 1) ? 1 :
                                         BUS_CLOCK_HALF_NS / MCLK_PERIOD_NS;
endpackage
`default_nettype wire

// File: verilog/bcpp_top.sv
// How it works
// - Four-pin port data register holds four latches.
// - Output mode drives the latch level.
// - Input mode read gives pins; write only latches.
// - Output mode read gives latch; write drives pins one cycle after the latch.
// - Latch resets to zero; input reads show pins.
// - Direction bit 0 output, 1 input; resets FFH.
// - Select bit 3 makes pin 3 hold request.
// - Select bit 2 drives hold grant on pin 2.
// - Select bit 1 drives bus clock on pin 1.
// - Select bit 0 makes pin 0 wait input.
// - Function select register resets to all port mode.
// - Pull-up enable bits connect pull-ups, reset zero.
// - Pull-down enable bits connect pull-downs, reset zero.
// - Byte and single-bit access; bit writes touch one.
// - Two-pin port latches behave like four-pin port.
// - Two-pin port has per-pin select and pulls.
// - Two-pin direction 0 output, 1 input; resets FFH.
// - Two-pin select bits drive chip selects out.
//
// Decided for this implementation: register access over AXI4-Lite.
`default_nettype none
module bcpp_top #(
  parameter int BUS_CLOCK_HALF = bcpp_pkg::BUS_CLOCK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // AXI4-Lite write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Four-pin port pins
  input wire logic [3:0] four_pin_in,
  output logic [3:0] four_pin_out,
  output logic [3:0] four_pin_oe,
  output logic [3:0] four_pin_pullup_en,
  output logic [3:0] four_pin_pulldown_en,
  // Two-pin port pins
  input wire logic [1:0] two_pin_in,
  output logic [1:0] two_pin_out,
  output logic [1:0] two_pin_oe,
  output logic [1:0] two_pin_pullup_en,
  output logic [1:0] two_pin_pulldown_en,
  // External bus controller side
  input wire logic bus_hold_grant_out,
  input wire logic [1:0] chip_select_out,
  output logic bus_hold_request_in,
  output logic bus_wait_in,
  output logic bus_base_clock_out
);

  // ---------------------------------------------------------------
  // Configuration check
  // ---------------------------------------------------------------
  if (BUS_CLOCK_HALF < 1 || BUS_CLOCK_HALF > 255) begin : g_bad_div
    $error("BUS_CLOCK_HALF must lie between 1 and 255.");
  end

  // ---------------------------------------------------------------
  // Port registers
  // ---------------------------------------------------------------
  logic [3:0] four_latch;
  logic [7:0] four_dir;
  logic [3:0] four_fsel;
  logic [1:0] two_latch;
  logic [7:0] two_dir;
  logic [1:0] two_fsel;
  logic [1:0] two_pu;
  logic [1:0] two_pd;
  logic [3:0] four_sync1;
  logic [3:0] four_sync2;
  logic [1:0] two_sync1;
  logic [1:0] two_sync2;
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] read_byte;
  logic read_hit;
  logic write_hit;
  logic [7:0] bus_clk_count;
  logic bus_clk_tick;

  // A bit access carries its index and value in byte lane 1, so a
  // single bit changes without a read-modify-write by software.
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] data,
                                       input logic [3:0] strb);
    logic [7:0] result;
    result = old;
    if (strb[0]) begin
      result = data[7:0];
    end else if (strb == bcpp_pkg::BIT_ACCESS_STRB) begin
      result[data[bcpp_pkg::BIT_INDEX_LSB +: 3]] = data[bcpp_pkg::BIT_VALUE_POS];
    end
    return result;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    four_sync1 <= four_pin_in;
    four_sync2 <= four_sync1;
    two_sync1 <= two_pin_in;
    two_sync2 <= two_sync1;
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr <= 32'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    unique case (aw_addr)
      bcpp_pkg::TWO_DATA_ADDR, bcpp_pkg::FOUR_DATA_ADDR, bcpp_pkg::TWO_DIR_ADDR,
      bcpp_pkg::FOUR_DIR_ADDR, bcpp_pkg::TWO_FSEL_ADDR, bcpp_pkg::FOUR_FSEL_ADDR,
      bcpp_pkg::TWO_PU_ADDR, bcpp_pkg::FOUR_PU_ADDR, bcpp_pkg::TWO_PD_ADDR,
      bcpp_pkg::FOUR_PD_ADDR: write_hit = 1'b1;
      default: write_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bcpp_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_hit ? bcpp_pkg::RESP_OKAY : bcpp_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes. Unused upper bits are not stored, except the
  // direction registers, which must read back FFH after reset.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      four_latch <= bcpp_pkg::LATCH_RESET[3:0];
      four_dir <= bcpp_pkg::DIR_RESET;
      four_fsel <= bcpp_pkg::FSEL_RESET[3:0];
      four_pin_pullup_en <= bcpp_pkg::PULL_RESET[3:0];
      four_pin_pulldown_en <= bcpp_pkg::PULL_RESET[3:0];
      two_latch <= bcpp_pkg::LATCH_RESET[1:0];
      two_dir <= bcpp_pkg::DIR_RESET;
      two_fsel <= bcpp_pkg::FSEL_RESET[1:0];
      two_pu <= bcpp_pkg::PULL_RESET[1:0];
      two_pd <= bcpp_pkg::PULL_RESET[1:0];
    end else if (do_write) begin
      unique case (aw_addr)
        bcpp_pkg::FOUR_DATA_ADDR: four_latch <= 4'(merge({4'h0, four_latch}, w_data, w_strb));
        bcpp_pkg::FOUR_DIR_ADDR: four_dir <= merge(four_dir, w_data, w_strb) | bcpp_pkg::FOUR_DIR_FIXED_ONES;
        bcpp_pkg::FOUR_FSEL_ADDR: four_fsel <= 4'(merge({4'h0, four_fsel}, w_data, w_strb));
        bcpp_pkg::FOUR_PU_ADDR: four_pin_pullup_en <= 4'(merge({4'h0, four_pin_pullup_en}, w_data, w_strb));
        bcpp_pkg::FOUR_PD_ADDR: four_pin_pulldown_en <= 4'(merge({4'h0, four_pin_pulldown_en}, w_data, w_strb));
        bcpp_pkg::TWO_DATA_ADDR: two_latch <= 2'(merge({6'h0, two_latch}, w_data, w_strb));
        bcpp_pkg::TWO_DIR_ADDR: two_dir <= merge(two_dir, w_data, w_strb);
        bcpp_pkg::TWO_FSEL_ADDR: two_fsel <= 2'(merge({6'h0, two_fsel}, w_data, w_strb));
        bcpp_pkg::TWO_PU_ADDR: two_pu <= 2'(merge({6'h0, two_pu}, w_data, w_strb));
        bcpp_pkg::TWO_PD_ADDR: two_pd <= 2'(merge({6'h0, two_pd}, w_data, w_strb));
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  always_comb begin
    read_hit = 1'b1;
    unique case (s_axi_araddr)
      bcpp_pkg::FOUR_DATA_ADDR: read_byte = {4'h0, (four_dir[3:0] & four_sync2) | (~four_dir[3:0] & four_latch)};
      bcpp_pkg::FOUR_DIR_ADDR: read_byte = four_dir;
      bcpp_pkg::FOUR_FSEL_ADDR: read_byte = {4'h0, four_fsel};
      bcpp_pkg::FOUR_PU_ADDR: read_byte = {4'h0, four_pin_pullup_en};
      bcpp_pkg::FOUR_PD_ADDR: read_byte = {4'h0, four_pin_pulldown_en};
      bcpp_pkg::TWO_DATA_ADDR: read_byte = {6'h0, (two_dir[1:0] & two_sync2) | (~two_dir[1:0] & two_latch)};
      bcpp_pkg::TWO_DIR_ADDR: read_byte = two_dir;
      bcpp_pkg::TWO_FSEL_ADDR: read_byte = {6'h0, two_fsel};
      bcpp_pkg::TWO_PU_ADDR: read_byte = {6'h0, two_pu};
      bcpp_pkg::TWO_PD_ADDR: read_byte = {6'h0, two_pd};
      default: begin
        read_byte = 8'h00;
        read_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= bcpp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h0, read_byte};
      s_axi_rresp <= read_hit ? bcpp_pkg::RESP_OKAY : bcpp_pkg::RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Bus base clock divider
  // ---------------------------------------------------------------
  assign bus_clk_tick = (bus_clk_count == 8'(BUS_CLOCK_HALF - 1));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_clk_count <= 8'h00;
      bus_base_clock_out <= 1'b0;
    end else if (bus_clk_tick) begin
      bus_clk_count <= 8'h00;
      bus_base_clock_out <= ~bus_base_clock_out;
    end else begin
      bus_clk_count <= bus_clk_count + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // Drivers add one register stage after a write; a select bit hands
  // the pin to the alternate function regardless of the direction bit.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      four_pin_out <= 4'h0;
      four_pin_oe <= 4'h0;
      two_pin_out <= 2'h0;
      two_pin_oe <= 2'h0;
    end else begin
      four_pin_out <= four_latch;
      four_pin_oe <= ~four_dir[3:0] & ~four_fsel;
      if (four_fsel[bcpp_pkg::HOLD_GRANT_POS]) begin
        four_pin_out[bcpp_pkg::HOLD_GRANT_POS] <= bus_hold_grant_out;
        four_pin_oe[bcpp_pkg::HOLD_GRANT_POS] <= 1'b1;
      end
      if (four_fsel[bcpp_pkg::BUS_CLOCK_POS]) begin
        four_pin_out[bcpp_pkg::BUS_CLOCK_POS] <= bus_base_clock_out;
        four_pin_oe[bcpp_pkg::BUS_CLOCK_POS] <= 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        two_pin_out[i] <= two_fsel[i] ? chip_select_out[i] : two_latch[i];
        two_pin_oe[i] <= two_fsel[i] | ~two_dir[i];
      end
    end
  end

  assign two_pin_pullup_en = two_pu;
  assign two_pin_pulldown_en = two_pd;

  // Deselected alternate inputs rest at the idle level so the bus
  // controller never sees a stray request from a port pin.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_hold_request_in <= bcpp_pkg::ALT_IN_IDLE;
      bus_wait_in <= bcpp_pkg::ALT_IN_IDLE;
    end else begin
      bus_hold_request_in <= four_fsel[bcpp_pkg::HOLD_REQUEST_POS] ?
                             four_sync2[bcpp_pkg::HOLD_REQUEST_POS] : bcpp_pkg::ALT_IN_IDLE;
      bus_wait_in <= four_fsel[bcpp_pkg::WAIT_POS] ?
                     four_sync2[bcpp_pkg::WAIT_POS] : bcpp_pkg::ALT_IN_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_four_data_byte_write;
    do_write && aw_addr == bcpp_pkg::FOUR_DATA_ADDR && w_strb[0];
  endsequence

  sequence s_four_data_bit_write;
    do_write && aw_addr == bcpp_pkg::FOUR_DATA_ADDR && w_strb == bcpp_pkg::BIT_ACCESS_STRB;
  endsequence

  a_latch_update: assert property (s_four_data_byte_write |=> four_latch == $past(w_data[3:0]))
    else $error("Latch did not take the written byte.");
  a_out_follow: assert property (s_four_data_byte_write ##1 (four_dir[3:0] == 4'h0 && four_fsel == 4'h0)
    |=> four_pin_out == $past(four_latch) && four_pin_oe == 4'hf)
    else $error("Written latch did not reach output pins.");
  a_drive_level: assert property (!four_dir[0] && !four_fsel[0] |=> four_pin_oe[0] && four_pin_out[0] == $past(four_latch[0]))
    else $error("Output pin not driven at latch level.");
  a_input_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == bcpp_pkg::FOUR_DATA_ADDR
    && four_dir[3] |=> s_axi_rvalid && s_axi_rdata[3] == $past(four_sync2[3]))
    else $error("Input-mode read did not return pin level.");
  a_bit_write: assert property ((s_four_data_bit_write and (w_data[10:8] == 3'h1))
    |=> four_latch[1] == $past(w_data[15]) && four_latch[0] == $past(four_latch[0])
    && four_latch[3:2] == $past(four_latch[3:2]))
    else $error("Bit write disturbed other bits.");
  a_dir_fixed: assert property (four_dir[7:6] == 2'h3)
    else $error("Direction bits 7 and 6 not fixed at one.");
  a_wait_pass: assert property (four_fsel[0] ##1 four_fsel[0] |-> bus_wait_in == $past(four_sync2[0]))
    else $error("Wait input not forwarded.");
  a_hold_req: assert property (!four_fsel[3] |=> bus_hold_request_in == bcpp_pkg::ALT_IN_IDLE)
    else $error("Hold request leaked from port pin.");
  a_grant_pin: assert property (four_fsel[2] |=> four_pin_oe[2] && four_pin_out[2] == $past(bus_hold_grant_out))
    else $error("Hold grant not driven.");
  a_ctrl_input: assert property ((four_fsel & 4'h9) != 4'h0 |=> (four_pin_oe & $past(four_fsel) & 4'h9) == 4'h0)
    else $error("Control-mode input pin driven.");
  a_cs_drive: assert property (two_fsel[0] |=> two_pin_oe[0] && two_pin_out[0] == $past(chip_select_out[0]))
    else $error("Chip select not driven.");
  a_write_resp: assert property (do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("Write response missing.");

endmodule // bcpp_top
`default_nettype wire

// File: dv/bcpp_pin_model.sv
`default_nettype none
module bcpp_pin_model #(
  parameter int W = 4
) (
  // Clock for the floating-pin pattern
  input wire logic mclk,
  // Drive and pull state from the device
  input wire logic [W-1:0] drv_out,
  input wire logic [W-1:0] drv_oe,
  input wire logic [W-1:0] pull_up,
  input wire logic [W-1:0] pull_down,
  // Outside driver on the board
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_level,
  // Resolved pin level
  output logic [W-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven, unpulled pin flips every cycle so a stale level never passes for a real one.
  logic [W-1:0] float_pat = '0;
  always @(posedge mclk) begin
    float_pat <= ~float_pat;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (drv_oe[i]) begin
        pin_level[i] = drv_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_level[i];
      end else if (pull_up[i]) begin
        pin_level[i] = 1'b1;
      end else if (pull_down[i]) begin
        pin_level[i] = 1'b0;
      end else begin
        pin_level[i] = float_pat[i];
      end
    end
  end
endmodule // bcpp_pin_model
`default_nettype wire

// File: dv/test_bus_control_pin_ports.sv
`default_nettype none
module test_bus_control_pin_ports;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int toggles;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, prev, prevb;
  logic [1:0] bresp, rresp;
  logic [3:0] f_in, f_out, f_oe, f_pu, f_pd;
  logic [3:0] f_ext_en = '0, f_ext = '0;
  logic [1:0] t_in, t_out, t_oe, t_pu, t_pd;
  logic grant = 1'b0;
  logic [1:0] cs = '0;
  logic hold_req, wait_in, bclk;
  logic [31:0] ra [6] = '{bcpp_pkg::FOUR_DIR_ADDR, bcpp_pkg::FOUR_FSEL_ADDR, bcpp_pkg::FOUR_PU_ADDR,
                          bcpp_pkg::FOUR_PD_ADDR, bcpp_pkg::TWO_DIR_ADDR, bcpp_pkg::TWO_FSEL_ADDR};
  logic [7:0] rv [6] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};

  always #12.5 mclk = ~mclk;

  bcpp_top #(.BUS_CLOCK_HALF(2)) i_bcpp_top (
    .mclk(mclk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .four_pin_in(f_in), .four_pin_out(f_out), .four_pin_oe(f_oe),
    .four_pin_pullup_en(f_pu), .four_pin_pulldown_en(f_pd),
    .two_pin_in(t_in), .two_pin_out(t_out), .two_pin_oe(t_oe),
    .two_pin_pullup_en(t_pu), .two_pin_pulldown_en(t_pd),
    .bus_hold_grant_out(grant), .chip_select_out(cs), .bus_hold_request_in(hold_req),
    .bus_wait_in(wait_in), .bus_base_clock_out(bclk)
  );
  bcpp_pin_model #(.W(4)) i_bcpp_pin_model_four (
    .mclk(mclk), .drv_out(f_out), .drv_oe(f_oe), .pull_up(f_pu), .pull_down(f_pd),
    .ext_en(f_ext_en), .ext_level(f_ext), .pin_level(f_in)
  );
  bcpp_pin_model #(.W(2)) i_bcpp_pin_model_two (
    .mclk(mclk), .drv_out(t_out), .drv_oe(t_oe), .pull_up(t_pu), .pull_down(t_pd),
    .ext_en(2'h0), .ext_level(2'h0), .pin_level(t_in)
  );
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("write response", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd_check(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check("read data", rdata, exp);
    check("read response", {30'h0, rresp}, {30'h0, er});
  endtask

  // Byte write on lane 0, and single-bit write with index and value packed into lane 1.
  task automatic wb(input logic [31:0] a, input logic [7:0] d);
    wr(a, {24'h0, d}, 4'h1, bcpp_pkg::RESP_OKAY);
  endtask

  task automatic wbit(input logic [31:0] a, input logic [2:0] i, input logic v);
    wr(a, {16'h0, v, 4'h0, i, 8'h0}, bcpp_pkg::BIT_ACCESS_STRB, bcpp_pkg::RESP_OKAY);
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 6; i++) rd_check(ra[i], {24'h0, rv[i]}, bcpp_pkg::RESP_OKAY);
    check("four oe", {28'h0, f_oe}, 32'h0);
    // Bits 7:6 are always written as one.
    wb(bcpp_pkg::FOUR_DIR_ADDR, 8'h00);
    rd_check(bcpp_pkg::FOUR_DIR_ADDR, 32'hc0, bcpp_pkg::RESP_OKAY);
    rd_check(bcpp_pkg::FOUR_DATA_ADDR, 32'h00, bcpp_pkg::RESP_OKAY);
    wb(bcpp_pkg::FOUR_DATA_ADDR, 8'h0a);
    repeat (2) @(posedge mclk);
    check("four out", {28'h0, f_out}, 32'ha);
    check("four oe", {28'h0, f_oe}, 32'hf);
    rd_check(bcpp_pkg::FOUR_DATA_ADDR, 32'h0a, bcpp_pkg::RESP_OKAY);
    // Inputs with pulls only: a write changes the latch, a read returns the pulled levels.
    wb(bcpp_pkg::FOUR_DIR_ADDR, 8'h0f);
    wb(bcpp_pkg::FOUR_PU_ADDR, 8'h05);
    wb(bcpp_pkg::FOUR_PD_ADDR, 8'h0a);
    wb(bcpp_pkg::FOUR_DATA_ADDR, 8'h03);
    repeat (4) @(posedge mclk);
    check("four pullup", {28'h0, f_pu}, 32'h5);
    check("four pulldown", {28'h0, f_pd}, 32'ha);
    check("four oe", {28'h0, f_oe}, 32'h0);
    rd_check(bcpp_pkg::FOUR_DATA_ADDR, 32'h05, bcpp_pkg::RESP_OKAY);
    wb(bcpp_pkg::FOUR_DIR_ADDR, 8'h00);
    rd_check(bcpp_pkg::FOUR_DATA_ADDR, 32'h03, bcpp_pkg::RESP_OKAY);
    wbit(bcpp_pkg::FOUR_DATA_ADDR, 3'h2, 1'b1);
    wbit(bcpp_pkg::FOUR_DATA_ADDR, 3'h0, 1'b0);
    wbit(bcpp_pkg::FOUR_DATA_ADDR, 3'h1, 1'b0);
    rd_check(bcpp_pkg::FOUR_DATA_ADDR, 32'h04, bcpp_pkg::RESP_OKAY);
    wbit(bcpp_pkg::FOUR_DIR_ADDR, 3'h3, 1'b1);
    rd_check(bcpp_pkg::FOUR_DIR_ADDR, 32'hc8, bcpp_pkg::RESP_OKAY);
    wbit(bcpp_pkg::FOUR_DIR_ADDR, 3'h3, 1'b0);
    // Control mode on every pin: outside levels low on the two inputs, grant high.
    f_ext_en <= 4'h9;
    f_ext <= 4'h0;
    grant <= 1'b1;
    wb(bcpp_pkg::FOUR_FSEL_ADDR, 8'h0f);
    rd_check(bcpp_pkg::FOUR_FSEL_ADDR, 32'h0f, bcpp_pkg::RESP_OKAY);
    repeat (5) @(posedge mclk);
    check("four oe control", {28'h0, f_oe}, 32'h6);
    check("grant pin", {31'h0, f_out[2]}, 32'h1);
    check("hold request", {31'h0, hold_req}, 32'h0);
    check("wait", {31'h0, wait_in}, 32'h0);
    #1;
    toggles = 0;
    repeat (8) begin
      prev = f_out[1];
      prevb = bclk;
      @(posedge mclk);
      #1;
      if (f_out[1] !== prev) toggles++;
      if (bclk !== prevb) toggles++;
    end
    check("bus clock toggles", toggles, 8);
    @(posedge mclk);
    grant <= 1'b0;
    repeat (3) @(posedge mclk);
    check("grant pin", {31'h0, f_out[2]}, 32'h0);
    wb(bcpp_pkg::FOUR_FSEL_ADDR, 8'h00);
    repeat (5) @(posedge mclk);
    check("hold request idle", {31'h0, hold_req}, 32'h1);
    check("wait idle", {31'h0, wait_in}, 32'h1);
    check("four out port", {28'h0, f_out}, 32'h4);
    // Two-pin port, bits 7:2 of its data always written as zero.
    wb(bcpp_pkg::TWO_DIR_ADDR, 8'h00);
    wb(bcpp_pkg::TWO_DATA_ADDR, 8'h02);
    repeat (2) @(posedge mclk);
    check("two out", {30'h0, t_out, t_oe}, 32'hb);
    rd_check(bcpp_pkg::TWO_DATA_ADDR, 32'h02, bcpp_pkg::RESP_OKAY);
    cs <= 2'h1;
    wbit(bcpp_pkg::TWO_FSEL_ADDR, 3'h0, 1'b1);
    repeat (2) @(posedge mclk);
    check("two chip select", {30'h0, t_out}, 32'h3);
    wb(bcpp_pkg::TWO_PU_ADDR, 8'h01);
    wb(bcpp_pkg::TWO_PD_ADDR, 8'h02);
    repeat (2) @(posedge mclk);
    check("two pulls", {28'h0, t_pu, t_pd}, 32'h6);
    wr(32'hfffff010, 32'h55, 4'h1, bcpp_pkg::RESP_DECERR);
    rd_check(32'hfffff010, 32'h0, bcpp_pkg::RESP_DECERR);
    stop_test();
  end
endmodule // test_bus_control_pin_ports
`default_nettype wire
